// ==== common/scan_pkg.sv ====
// shared constants for the converter scan sequencer
package scan_pkg;
	localparam int RES_W        = 12;
	localparam int NCH          = 16;
	localparam int NCH_BASE     = 8;
	localparam int CLK_HZ       = 50000000;
	localparam int CONV_MAX_HZ  = 18000000;
	localparam int CONV_DIV     = (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
	localparam int CONV_CLOCKS  = 18;
	localparam int SMP_W        = 8;
	localparam int THRU_MAX_SPS = 1000000;
	localparam int SLOT_MIN_CYC = (CLK_HZ + THRU_MAX_SPS - 1) / THRU_MAX_SPS;
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CHEN    = 8'h04;
	localparam logic [7:0] REG_FWSEL   = 8'h08;
	localparam logic [7:0] REG_LIMLO   = 8'h0c;
	localparam logic [7:0] REG_LIMHI   = 8'h10;
	localparam logic [7:0] REG_STAT    = 8'h14;
	localparam logic [7:0] REG_INTCLR  = 8'h18;
	localparam logic [7:0] REG_INTEN   = 8'h1c;
	localparam logic [7:0] REG_STATE   = 8'h20;
	localparam logic [7:0] REG_SWCTL   = 8'h24;
	localparam logic [7:0] REG_SMP0    = 8'h40;
	localparam logic [7:0] REG_RES0    = 8'h80;
	localparam int CTRL_START   = 0;
	localparam int CTRL_CONT    = 1;
	localparam int CTRL_FWMODE  = 2;
	localparam int CTRL_EXPAND  = 3;
	localparam int CTRL_REF_LO  = 4;
	localparam int CTRL_TEMP    = 6;
	localparam int CTRL_FWGO    = 7;
	localparam int ST_RANGE     = 0;
	localparam int ST_DONE      = 1;
	localparam int NEVT         = 2;
	localparam logic [7:0] SMP_RST   = 8'h04;
	localparam logic [11:0] LIMHI_RST = 12'hfff;
	localparam logic [3:0] TEMP_CH   = 4'hf;
endpackage

// ==== src/conv_clock_div.sv ====
// divider making the converter clock enable pulse
`timescale 1ns/10ps
module conv_clock_div
	import scan_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RST,
	input  wire logic run,
	output logic      tick
);
	logic [7:0] cnt_ff;
	wire  last = (cnt_ff == 8'(CONV_DIV - 1));

	// count clk cycles, one pulse per converter clock period
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			cnt_ff <= 8'h00;
		else if (!run || last)
			cnt_ff <= 8'h00;
		else
			cnt_ff <= cnt_ff + 8'h01;
	end

	assign tick = run && last;
endmodule

// ==== src/sar_adc_scan_sequencer.sv ====
// scan sequencer controlling a 12-bit successive approximation converter
// Summary of operation
// - results are 12 bits wide and slots are never shorter than one microsecond.
// - the converter clock enable runs at no more than 18 MHz and a conversion takes 18 of them.
// - eight channels are scanned, expandable to sixteen by a control bit.
// - once started the scan walks all enabled channels without software help.
// - the next channel is selected as the previous slot ends, with no idle slot.
// - the channel is chosen by the scan machine or by firmware, per a control bit.
// - each channel owns a result register readable after the scan.
// - each channel has its own sample time applied whenever it is converted.
// - software sets low and high limits and a result outside them raises an interrupt.
// - the range check is done as each result arrives, not at scan end.
// - the reference is one of three internal sources or the external pin.
// - the acquisition window is programmable to allow slow drivers to settle.
// - the scan machine may drive opamp analog switch control bit 0 from its sampling phase.
// - the temperature sensor may be routed in as a converter input.
// - the converter does not run while a deep low-power mode is requested.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module sar_adc_scan_sequencer
	import scan_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic [31:0]      RDATA,
	output logic             IRQ,
	input  wire logic        DEEP_LOW_POWER,
	output logic [3:0]       MUX_SEL,
	output logic             TEMP_SEL,
	output logic [1:0]       REF_SEL,
	output logic             SAMPLE,
	output logic             CONV_CLK_EN,
	output logic             CONV_START,
	input  wire logic        CONV_DONE,
	input  wire logic [11:0] CONV_RESULT,
	output logic [7:0]       OPAMP_SW
);
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_SAMPLE = 4'b0010,
		S_CONV   = 4'b0100,
		S_STORE  = 4'b1000
	} scan_state_t;

	scan_state_t      state_ff, nxt_state;
	logic [7:0]       ctrl_ff;
	logic [15:0]      chen_ff;
	logic [3:0]       fwsel_ff;
	logic [11:0]      limlo_ff, limhi_ff;
	logic [NEVT-1:0]  stat_ff, inten_ff, nxt_stat;
	logic [7:0]       swctl_ff;
	logic [7:0]       smp_ff [NCH];
	logic [11:0]      res_ff [NCH];
	logic [3:0]       ch_ff, nxt_ch;
	logic [7:0]       cnt_ff;
	logic [5:0]       slot_ff;
	logic             run_ff;
	logic [11:0]      last_res_ff;
	logic [31:0]      rdata_ff;
	logic             tick;

	// first enabled channel at or after a start index, wraps to none flag
	function automatic logic [4:0] next_en(input logic [15:0] en, input logic [4:0] from,
		input logic expand);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && 5'(i) >= from && (expand || i < NCH_BASE))
				r = 5'(i);
		end
		return r;
	endfunction

	// bus decode
	wire wr_ctrl  = WR && ADDR == REG_CTRL;
	wire wr_chen  = WR && ADDR == REG_CHEN;
	wire wr_fwsel = WR && ADDR == REG_FWSEL;
	wire wr_limlo = WR && ADDR == REG_LIMLO;
	wire wr_limhi = WR && ADDR == REG_LIMHI;
	wire wr_clr   = WR && ADDR == REG_INTCLR;
	wire wr_inten = WR && ADDR == REG_INTEN;
	wire wr_swctl = WR && ADDR == REG_SWCTL;
	wire wr_smp   = WR && ADDR[7:6] == REG_SMP0[7:6];
	wire [3:0] smp_idx = ADDR[5:2];
	wire [3:0] res_idx = ADDR[5:2];

	// control fields
	wire       fw_mode  = ctrl_ff[CTRL_FWMODE];
	wire       expand   = ctrl_ff[CTRL_EXPAND];
	wire       cont     = ctrl_ff[CTRL_CONT];
	wire       start_req = wr_ctrl && WDATA[CTRL_START];
	wire       fwgo_req = wr_ctrl && WDATA[CTRL_FWGO];
	wire       blocked  = DEEP_LOW_POWER;
	wire [4:0] first_ch = next_en(chen_ff, 5'h00, expand);
	wire [4:0] after_ch = next_en(chen_ff, {1'b0, ch_ff} + 5'h01, expand);
	wire       conv_end = CONV_DONE && state_ff == S_CONV;
	wire       out_range = CONV_RESULT < limlo_ff || CONV_RESULT > limhi_ff;
	wire       slot_ok  = slot_ff >= 6'(SLOT_MIN_CYC - 1);
	wire       smp_done = tick && cnt_ff == 8'h00;

	// scan state machine
	always_comb begin
		nxt_state = state_ff;
		nxt_ch    = ch_ff;
		case (state_ff)
			S_IDLE: begin
				if (!blocked && fw_mode && fwgo_req) begin
					nxt_state = S_SAMPLE;
					nxt_ch    = fwsel_ff;
				end else if (!blocked && !fw_mode && start_req && !first_ch[4]) begin
					nxt_state = S_SAMPLE;
					nxt_ch    = first_ch[3:0];
				end
			end
			S_SAMPLE: begin
				if (blocked)
					nxt_state = S_IDLE;
				else if (smp_done)
					nxt_state = S_CONV;
			end
			S_CONV: begin
				if (blocked)
					nxt_state = S_IDLE;
				else if (conv_end && cnt_ff == 8'h00)
					nxt_state = S_STORE;
			end
			S_STORE: begin
				if (!slot_ok) begin
					nxt_state = S_STORE;
				end else if (fw_mode || blocked) begin
					nxt_state = S_IDLE;
				end else if (!after_ch[4]) begin
					nxt_state = S_SAMPLE;
					nxt_ch    = after_ch[3:0];
				end else if (cont && !first_ch[4]) begin
					nxt_state = S_SAMPLE;
					nxt_ch    = first_ch[3:0];
				end else begin
					nxt_state = S_IDLE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	// sticky events: set wins over clear
	wire store_now = state_ff == S_STORE && slot_ok;
	wire scan_end  = store_now && !fw_mode && after_ch[4];
	always_comb begin
		nxt_stat = stat_ff;
		if (wr_clr)
			nxt_stat = stat_ff & ~WDATA[NEVT-1:0];
		if (conv_end && out_range)
			nxt_stat[ST_RANGE] = 1'b1;
		if (scan_end)
			nxt_stat[ST_DONE] = 1'b1;
	end

	// state, channel and timing counters
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_ff <= S_IDLE;
			ch_ff    <= 4'h0;
			cnt_ff   <= 8'h00;
			slot_ff  <= 6'h00;
		end else begin
			state_ff <= nxt_state;
			ch_ff    <= nxt_ch;
			if (nxt_state == S_SAMPLE && state_ff != S_SAMPLE)
				cnt_ff <= smp_ff[nxt_ch];
			else if (state_ff == S_SAMPLE && smp_done)
				cnt_ff <= 8'(CONV_CLOCKS - 1);
			else if (tick && cnt_ff != 8'h00)
				cnt_ff <= cnt_ff - 8'h01;
			if (nxt_state == S_SAMPLE && state_ff != S_SAMPLE)
				slot_ff <= 6'h00;
			else if (slot_ff != 6'h3f)
				slot_ff <= slot_ff + 6'h01;
		end
	end

	// converter run flag for the clock divider
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			run_ff <= 1'b0;
		else
			run_ff <= nxt_state == S_SAMPLE || nxt_state == S_CONV;
	end

	conv_clock_div u_div (
		.CLK  (CLK),
		.RST  (RST),
		.run  (run_ff),
		.tick (tick)
	);

	// software registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_ff  <= 8'h00;
			chen_ff  <= 16'h0000;
			fwsel_ff <= 4'h0;
			limlo_ff <= 12'h000;
			limhi_ff <= LIMHI_RST;
			stat_ff  <= '0;
			inten_ff <= '0;
			swctl_ff <= 8'h00;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= WDATA[7:0] & ~8'h81;                   // start and go self-clear
			if (wr_chen)
				chen_ff <= WDATA[15:0];
			if (wr_fwsel)
				fwsel_ff <= WDATA[3:0];
			if (wr_limlo)
				limlo_ff <= WDATA[11:0];
			if (wr_limhi)
				limhi_ff <= WDATA[11:0];
			if (wr_inten)
				inten_ff <= WDATA[NEVT-1:0];
			if (wr_swctl)
				swctl_ff <= WDATA[7:0];
			stat_ff <= nxt_stat;
		end
	end

	// per-channel sample times and result holding registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NCH; i++) begin
				smp_ff[i] <= SMP_RST;
				res_ff[i] <= 12'h000;
			end
			last_res_ff <= 12'h000;
		end else begin
			if (wr_smp)
				smp_ff[smp_idx] <= WDATA[7:0];
			if (conv_end) begin
				res_ff[ch_ff] <= CONV_RESULT;
				last_res_ff   <= CONV_RESULT;
			end
		end
	end

	// read mux
	wire [31:0] rd_val =
		ADDR == REG_CTRL  ? {24'h0, ctrl_ff} :
		ADDR == REG_CHEN  ? {16'h0, chen_ff} :
		ADDR == REG_FWSEL ? {28'h0, fwsel_ff} :
		ADDR == REG_LIMLO ? {20'h0, limlo_ff} :
		ADDR == REG_LIMHI ? {20'h0, limhi_ff} :
		ADDR == REG_STAT  ? {30'h0, stat_ff} :
		ADDR == REG_INTEN ? {30'h0, inten_ff} :
		ADDR == REG_STATE ? {12'h0, last_res_ff, state_ff, ch_ff} :
		ADDR == REG_SWCTL ? {24'h0, swctl_ff} :
		ADDR[7:6] == REG_SMP0[7:6] ? {24'h0, smp_ff[smp_idx]} :
		ADDR[7:6] == REG_RES0[7:6] ? {20'h0, res_ff[res_idx]} :
		32'h0;

	// read data one cycle after the strobe
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			rdata_ff <= 32'h0;
		else if (RD)
			rdata_ff <= rd_val;
		else
			rdata_ff <= 32'h0;
	end

	// bus, interrupt and analog side outputs
	assign RDATA       = rdata_ff;
	assign IRQ         = |(stat_ff & inten_ff);
	assign MUX_SEL     = ch_ff;
	assign TEMP_SEL    = ctrl_ff[CTRL_TEMP] && ch_ff == TEMP_CH;
	assign REF_SEL     = ctrl_ff[CTRL_REF_LO+1:CTRL_REF_LO];
	assign SAMPLE      = state_ff == S_SAMPLE;
	assign CONV_CLK_EN = tick;
	assign CONV_START  = state_ff == S_SAMPLE && smp_done;
	assign OPAMP_SW    = swctl_ff[7] ? (swctl_ff & 8'h7f) | {7'h0, SAMPLE} :
		swctl_ff;
endmodule

// ==== verif/conv_core_model.sv ====
// behavioural converter core answering each conversion start
`timescale 1ns/10ps
module conv_core_model (
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire logic			tick,
	input	wire logic			start,
	input	wire logic [3:0]	ch,
	input	wire logic [11:0]	salt,
	input	wire logic [3:0]	extra,
	output	logic				done,
	output	logic [11:0]		result
);
	int				n;
	logic [3:0]		ch_l;
	logic [11:0]	last;
	// result lines are valid only with done, otherwise they show a flipped value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			n = -1;
			last = 12'h0;
			done <= 1'b0;
			result <= 12'hfff;
		end else begin
			done <= 1'b0;
			result <= ~last;
			if (start) begin
				n = 0;
				ch_l = ch;
			end else if (n >= 0 && tick)
				n++;
			if (n == 18 + extra) begin
				n = -1;
				last = {ch_l, 8'h00} ^ salt;
				done <= 1'b1;
				result <= last;
			end
		end
	end
endmodule

// ==== verif/scan_seq_properties.sv ====
// port assertions for the scan sequencer
`timescale 1ns/10ps
module scan_seq_properties
	import scan_pkg::*;
(
	input	wire logic			CLK,
	input	wire logic			RST,
	input	wire logic [7:0]	ADDR,
	input	wire logic [31:0]	WDATA,
	input	wire logic			WR,
	input	wire logic			RD,
	input	wire logic [31:0]	RDATA,
	input	wire logic			DEEP_LOW_POWER,
	input	wire logic [3:0]	MUX_SEL,
	input	wire logic			TEMP_SEL,
	input	wire logic [1:0]	REF_SEL,
	input	wire logic			SAMPLE,
	input	wire logic			CONV_CLK_EN,
	input	wire logic			CONV_START
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [5:0] gap_ff;
	// cycles since the last conversion start, saturating
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			gap_ff <= 6'h3f;
		else if (CONV_START)
			gap_ff <= 6'h00;
		else if (gap_ff != 6'h3f)
			gap_ff <= gap_ff + 6'h01;
	end
	rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
		else $error("read data not zero outside a read");
	ref_select_a: assert property (WR && ADDR == REG_CTRL |=> REF_SEL == $past(WDATA[5:4]))
		else $error("reference select does not follow control");
	temp_route_a: assert property (TEMP_SEL |-> MUX_SEL == TEMP_CH)
		else $error("temperature routed on a wrong channel");
	clk_rate_a: assert property (CONV_CLK_EN |=> !CONV_CLK_EN [*2])
		else $error("converter clock enable too fast");
	start_pulse_a: assert property (CONV_START |-> $past(SAMPLE) ##1 !CONV_START)
		else $error("conversion start not a pulse after sampling");
	chan_hold_a: assert property (SAMPLE && $past(SAMPLE) |-> $stable(MUX_SEL))
		else $error("channel changed during sampling");
	deep_block_a: assert property (DEEP_LOW_POWER [*3] |-> !SAMPLE && !CONV_START)
		else $error("converter active in deep low power");
	slot_len_a: assert property (CONV_START |-> gap_ff >= 6'd49)
		else $error("conversion slots closer than one microsecond");
endmodule
bind sar_adc_scan_sequencer scan_seq_properties i_props (.CLK, .RST, .ADDR, .WDATA, .WR,
	.RD, .RDATA, .DEEP_LOW_POWER, .MUX_SEL, .TEMP_SEL, .REF_SEL, .SAMPLE, .CONV_CLK_EN,
	.CONV_START);

// ==== verif/sar_adc_scan_sequencer_test.sv ====
// self-checking bench for the scan sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sar_adc_scan_sequencer_test
	import scan_pkg::*;
;
	logic			clk, rst, wr, rd, dlp, irq, sample, tick, start, done, temp_sel, mon, rng;
	logic [7:0]		addr, opamp_sw;
	logic [31:0]	wdata, rdata, chen, seed;
	logic [3:0]		mux_sel, extra;
	logic [1:0]		ref_sel;
	logic [11:0]	salt, result, s;
	int				n_mismatch, n_checks, exp_res[16], order_q[$];
	sar_adc_scan_sequencer i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .IRQ(irq), .DEEP_LOW_POWER(dlp), .MUX_SEL(mux_sel),
		.TEMP_SEL(temp_sel), .REF_SEL(ref_sel), .SAMPLE(sample), .CONV_CLK_EN(tick),
		.CONV_START(start), .CONV_DONE(done), .CONV_RESULT(result), .OPAMP_SW(opamp_sw));
	conv_core_model i_core (.clk(clk), .rst(rst), .tick(tick), .start(start), .ch(mux_sel),
		.salt(salt), .extra(extra), .done(done), .result(result));
	// xorshift source of the random stimulus
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	// bounded wait for sampling (sel high) or for the interrupt
	task automatic wt(input logic sel);
		int k;
		k = 0;
		while (!(sel ? sample : irq) && k < 8000) begin
			@(posedge clk);
			k++;
		end
		#1;
		if (k >= 8000) begin
			n_mismatch++;
			conclude();
		end
	endtask
	// scan order model: each conversion start takes the next expected channel
	always @(posedge clk)
		if (mon && start)
			`CHK(mux_sel, 4'(order_q.pop_front()))
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{wr, rd, dlp, mon, addr, wdata, salt, extra} = '0;
		seed = 32'h81b2b45f;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_rd(REG_LIMHI, 32'hfff);
		chk_rd(REG_SMP0, 32'h4);
		chk_rd(REG_STAT, 32'h0);
		chk_rd(8'hfc, 32'h0);
		for (int r = 0; r < 4; r++) begin
			wr_reg(REG_CTRL, r << 4);
			#1 `CHK(ref_sel, 2'(r))
		end
		// one plain scan of a random subset of the eight base inputs, then an expanded one with the sensor
		for (int p = 0; p < 2; p++) begin
			chen = p ? (rnd() & 32'hffff) | 32'h8000 : (rnd() & 32'hff) | 32'h1;
			s = 12'(rnd());
			salt <= s;
			extra <= 4'(rnd() & 3);
			rng = 1'b0;
			for (int i = 0; i < 16; i++) begin
				wr_reg(REG_SMP0 + 8'(4 * i), rnd() & 32'h7);
				exp_res[i] = {4'(i), 8'h00} ^ s;
				if (chen[i])
					order_q.push_back(i);
				if (chen[i] && (exp_res[i] < 32'h200 || exp_res[i] > 32'he00))
					rng = 1'b1;
			end
			wr_reg(REG_LIMLO, 32'h200);
			wr_reg(REG_LIMHI, 32'he00);
			wr_reg(REG_CHEN, chen);
			wr_reg(REG_INTEN, 32'h2);
			// expand is taken from the stored control word, so set it before the start
			wr_reg(REG_CTRL, p << 3 | p << 6);
			mon <= 1'b1;
			wr_reg(REG_CTRL, 32'h1 | p << 3 | p << 6);
			wt(1'b0);
			mon <= 1'b0;
			`CHK(order_q.size(), 0)
			chk_rd(REG_STAT, {30'h0, 1'b1, rng});
			for (int i = 0; i < 16; i++)
				if (chen[i])
					chk_rd(REG_RES0 + 8'(4 * i), exp_res[i]);
			wr_reg(REG_INTEN, 32'h1);
			#1 `CHK(irq, rng)
			wr_reg(REG_INTCLR, 32'h3);
			chk_rd(REG_STAT, 32'h0);
		end
		// abort in mid-scan, then a start refused while blocked
		wr_reg(REG_CTRL, 32'h1);
		wt(1'b1);
		dlp <= 1'b1;
		wr_reg(REG_CTRL, 32'h0);
		wr_reg(REG_CTRL, 32'h1);
		#1 `CHK(sample, 1'b0)
		chk_rd(REG_STAT, 32'h0);
		wr_reg(REG_CTRL, 32'h0);
		dlp <= 1'b0;
		// firmware-chosen channel with the opamp switch following sampling
		wr_reg(REG_SWCTL, 32'h80);
		wr_reg(REG_FWSEL, 32'h5);
		// firmware mode must already be stored when the go bit arrives
		wr_reg(REG_CTRL, 32'h4);
		wr_reg(REG_CTRL, 32'h84);
		wt(1'b1);
		`CHK(mux_sel, 4'h5)
		`CHK(opamp_sw[0], 1'b1)
		conclude();
	end
endmodule
